// file: dram_timing_pkg.sv
// Shared constants for the command-timing controller and device ends.
// Assumes a single 10 MHz clock shared by both ends; all counts in clock edges.
package dram_timing_pkg;

  // ----------------------------------------
  // Clock and conversion
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 100000;

  // Ceiling division used for ns/ps parameters converted to edges
  function automatic int cycles_up(input int time_ps);
    int c;
    c = (time_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------
  // Timing figures
  // ----------------------------------------
  localparam int MODE_SET_SPACING = 4;
  localparam int PRECHARGE_PERIOD_PS = 13500;
  localparam int PRECHARGE_CYC = cycles_up(PRECHARGE_PERIOD_PS);
  localparam int WRITE_RECOVERY_TIME_PS = 15000;
  localparam int WRITE_RECOVERY_CYC = cycles_up(WRITE_RECOVERY_TIME_PS);
  localparam int WRITE_LATENCY_CYCLES = 5;
  localparam int WR_START_FULL = 4;
  localparam int WR_START_CHOP = 2;
  localparam int REFRESH_TO_POWERDOWN_GAP = 1;
  localparam int POWERDOWN_EXIT_LOOP_DELAY_PS = 24000;
  localparam int POWERDOWN_EXIT_LOOP_CYC = cycles_up(POWERDOWN_EXIT_LOOP_DELAY_PS);
  localparam int TERMINATION_HOLD_SHORT = 4;
  localparam int TERMINATION_HOLD_LONG = 6;
  localparam int IMPEDANCE_SHORT_CAL_CYC = 64;
  localparam int REFRESH_INTERVAL_PS = 7800000;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_PS / CLK_PERIOD_PS;
  localparam int POSTED_REFRESH_MAX = 8;
  localparam int READOUT_TO_MODE_SET = 1;
  localparam int ACTIVE_TO_ACTIVE = 2;
  localparam int BUSY_CNT_W = 8;

  // ----------------------------------------
  // Commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP      = 4'h0,
    CMD_MODE_SET = 4'h1,
    CMD_REFRESH  = 4'h2,
    CMD_PRECHARGE = 4'h3,
    CMD_ACTIVATE = 4'h4,
    CMD_WRITE    = 4'h5,
    CMD_READ     = 4'h6,
    CMD_READ_AP  = 4'h7,
    CMD_ZQ_SHORT = 4'h8,
    CMD_READOUT  = 4'h9
  } dram_cmd_e;

  // Burst kind of a write: fixed chop by mode register or eight/on-the-fly chop
  typedef enum logic [1:0] {
    BURST_EIGHT    = 2'h0,
    BURST_CHOP_OTF = 2'h1,
    BURST_CHOP_FIX = 2'h2
  } burst_e;

endpackage

// file: dram_cmd_if.sv
// Command link between memory controller and device model logic.
// Assumes both ends share clk and reset supplied by the testbench.
`timescale 1ns/1ns
`default_nettype none
interface dram_cmd_if
  import dram_timing_pkg::*;
(
  input wire logic clk_i
);
  dram_cmd_e cmd;
  burst_e burst;
  logic termination_control;
  logic clock_enable;
  logic loop_locked;
  logic wr_start;
  logic cal_busy;
  logic timing_fault;

  modport ctrl (
    input clk_i,
    output cmd,
    output burst,
    output termination_control,
    output clock_enable,
    input loop_locked,
    input cal_busy,
    input timing_fault
  );

  modport dev (
    input clk_i,
    input cmd,
    input burst,
    input termination_control,
    input clock_enable,
    output loop_locked,
    output wr_start,
    output cal_busy,
    output timing_fault
  );
endinterface
`default_nettype wire

// file: dram_device_end.sv
// Device end: starts internal writes, runs short calibration, tracks power-down.
// Assumes the controller end keeps its own spacing; the device only flags faults.
`timescale 1ns/1ns
`default_nettype none
module dram_device_end
(
  input wire logic clk_i,
  input wire logic reset_i,
  dram_cmd_if.dev link,
  output logic wr_start_o,
  output logic cal_busy_o,
  output logic powered_down_o,
  output logic timing_fault_o
);
  import dram_timing_pkg::*;

  localparam int WR_PIPE_LEN = WRITE_LATENCY_CYCLES + WR_START_FULL;
  logic [WR_PIPE_LEN-1:0] wr_pipe_q;
  logic [BUSY_CNT_W-1:0] cal_cnt_q;
  logic [BUSY_CNT_W-1:0] op_cnt_q;
  logic [2:0] ms_cnt_q;
  logic fault_q;

  // ----------------------------------------
  // Internal write start
  // ----------------------------------------
  // Shift line, not a counter: a second write must not cancel a pending start
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      wr_pipe_q <= '0;
    else if (link.cmd == CMD_WRITE && link.burst == BURST_CHOP_FIX)
      wr_pipe_q <= (wr_pipe_q >> 1) | (WR_PIPE_LEN'(1) << (WRITE_LATENCY_CYCLES + WR_START_CHOP - 1));
    else if (link.cmd == CMD_WRITE)
      wr_pipe_q <= (wr_pipe_q >> 1) | (WR_PIPE_LEN'(1) << (WR_PIPE_LEN - 1));
    else
      wr_pipe_q <= wr_pipe_q >> 1;
  end
  assign wr_start_o = wr_pipe_q[0];

  // ----------------------------------------
  // Short calibration
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cal_cnt_q <= '0;
    else if (link.cmd == CMD_ZQ_SHORT)
      cal_cnt_q <= BUSY_CNT_W'(IMPEDANCE_SHORT_CAL_CYC);
    else if (cal_cnt_q != '0)
      cal_cnt_q <= cal_cnt_q - 1'b1;
  end
  assign cal_busy_o = (cal_cnt_q != '0);

  // ----------------------------------------
  // Row operations finish under clock enable low
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      op_cnt_q <= '0;
    else if (link.cmd == CMD_ACTIVATE || link.cmd == CMD_PRECHARGE || link.cmd == CMD_REFRESH)
      op_cnt_q <= BUSY_CNT_W'(PRECHARGE_CYC);
    else if (op_cnt_q != '0)
      op_cnt_q <= op_cnt_q - 1'b1;
  end
  // No clock-period ceiling here: all counters step per edge only
  assign powered_down_o = !link.clock_enable && (op_cnt_q == '0);

  // ----------------------------------------
  // Fault flag: mode sets closer than the edge spacing
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ms_cnt_q <= '0;
      fault_q <= 1'b0;
    end
    else
    begin
      if (link.cmd == CMD_MODE_SET)
      begin
        if (ms_cnt_q != '0)
          fault_q <= 1'b1;
        ms_cnt_q <= 3'(MODE_SET_SPACING - 1);
      end
      else if (ms_cnt_q != '0)
        ms_cnt_q <= ms_cnt_q - 1'b1;
    end
  end
  assign timing_fault_o = fault_q;

  assign link.wr_start = wr_start_o;
  assign link.cal_busy = cal_busy_o;
  assign link.timing_fault = fault_q;
  assign link.loop_locked = 1'b1;
endmodule // dram_device_end
`default_nettype wire

// file: dram_ctrl_end.sv
// Controller end: issues requested commands only when the spacing counters that apply to each command expire.
// Assumes the user holds a request until it is accepted.
`timescale 1ns/1ns
`default_nettype none
module dram_ctrl_end
#(
  parameter int REFRESH_CYC = dram_timing_pkg::REFRESH_INTERVAL_CYC
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  dram_cmd_if.ctrl link,
  input wire dram_timing_pkg::dram_cmd_e req_cmd_i,
  input wire dram_timing_pkg::burst_e req_burst_i,
  input wire logic req_valid_i,
  input wire logic req_term_i,
  input wire logic req_powerdown_i,
  output logic req_ready_o,
  output logic refresh_forced_o,
  output logic [3:0] refresh_debt_o,
  output logic reinit_needed_o
);
  import dram_timing_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_REFRESH = 2'b01,
    ST_REINIT = 2'b10
  } ctrl_state_e;

  ctrl_state_e state_q;
  dram_cmd_e cmd_q;
  burst_e burst_q;
  logic term_q;
  logic cke_q;
  logic [BUSY_CNT_W-1:0] ms_gap_q;
  logic [BUSY_CNT_W-1:0] row_gap_q;
  logic [BUSY_CNT_W-1:0] pd_gap_q;
  logic [BUSY_CNT_W-1:0] cal_gap_q;
  logic [BUSY_CNT_W-1:0] term_hold_q;
  logic [15:0] ref_tmr_q;
  logic [3:0] debt_q;
  logic allowed;
  logic issue;

  function automatic logic [BUSY_CNT_W-1:0] dec(input logic [BUSY_CNT_W-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction

  // ----------------------------------------
  // Command legality
  // ----------------------------------------
  always_comb
  begin
    allowed = cke_q && cal_gap_q == '0;
    case (req_cmd_i)
      CMD_MODE_SET: allowed = allowed && ms_gap_q == '0;
      CMD_ACTIVATE, CMD_REFRESH: allowed = allowed && row_gap_q == '0;
      CMD_READ, CMD_READ_AP: allowed = allowed && link.loop_locked;
      default: allowed = allowed;
    endcase
    if (req_term_i && !link.loop_locked)
      allowed = 1'b0;
    if (term_q && !req_term_i && term_hold_q != '0)
      allowed = 1'b0;
    if (state_q != ST_RUN)
      allowed = 1'b0;
  end
  assign req_ready_o = allowed;
  assign issue = req_valid_i && allowed;

  // ----------------------------------------
  // Command register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cmd_q <= CMD_NOP;
      burst_q <= BURST_EIGHT;
      term_q <= 1'b0;
    end
    else if (state_q == ST_REFRESH && row_gap_q == '0 && cal_gap_q == '0 && cke_q)
    begin
      cmd_q <= CMD_REFRESH;
      burst_q <= BURST_EIGHT;
    end
    else if (issue)
    begin
      cmd_q <= req_cmd_i;
      burst_q <= req_burst_i;
      term_q <= req_term_i;
    end
    else
      cmd_q <= CMD_NOP;
  end

  // ----------------------------------------
  // Spacing counters, in edges
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ms_gap_q <= '0;
      row_gap_q <= '0;
      cal_gap_q <= '0;
    end
    else
    begin
      ms_gap_q <= (cmd_q == CMD_MODE_SET) ? BUSY_CNT_W'(MODE_SET_SPACING - 2) :
        (cmd_q == CMD_READOUT) ? BUSY_CNT_W'(READOUT_TO_MODE_SET) : dec(ms_gap_q);
      // Periods of two edges or less are already met by the command register
      row_gap_q <= (cmd_q == CMD_PRECHARGE) ? ((PRECHARGE_CYC > 2) ? BUSY_CNT_W'(PRECHARGE_CYC - 2) : '0) :
        (cmd_q == CMD_ACTIVATE) ? BUSY_CNT_W'(ACTIVE_TO_ACTIVE) : dec(row_gap_q);
      cal_gap_q <= (cmd_q == CMD_ZQ_SHORT) ? BUSY_CNT_W'(IMPEDANCE_SHORT_CAL_CYC - 2) : dec(cal_gap_q);
    end
  end

  // ----------------------------------------
  // Termination hold
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      term_hold_q <= '0;
    else if (issue && req_term_i && !term_q)
      term_hold_q <= (req_cmd_i == CMD_WRITE && req_burst_i == BURST_EIGHT) ?
        BUSY_CNT_W'(TERMINATION_HOLD_LONG - 1) :
        BUSY_CNT_W'(TERMINATION_HOLD_SHORT - 1);
    else if (issue && req_term_i && req_cmd_i == CMD_WRITE && req_burst_i == BURST_EIGHT)
      term_hold_q <= BUSY_CNT_W'(TERMINATION_HOLD_LONG - 1);
    else
      term_hold_q <= dec(term_hold_q);
  end

  // ----------------------------------------
  // Power-down entry
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pd_gap_q <= '0;
    else if (cmd_q == CMD_WRITE)
      pd_gap_q <= (burst_q == BURST_CHOP_FIX) ?
        BUSY_CNT_W'(WRITE_LATENCY_CYCLES + WR_START_CHOP + WRITE_RECOVERY_CYC) :
        BUSY_CNT_W'(WRITE_LATENCY_CYCLES + WR_START_FULL + WRITE_RECOVERY_CYC);
    else if (cmd_q == CMD_REFRESH)
      pd_gap_q <= BUSY_CNT_W'(REFRESH_TO_POWERDOWN_GAP + POWERDOWN_EXIT_LOOP_CYC);
    else
      pd_gap_q <= dec(pd_gap_q);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cke_q <= 1'b1;
    // The gap counter loads one edge late, so the command on the link blocks too
    else if (req_powerdown_i && pd_gap_q == '0 && state_q == ST_RUN && !issue &&
      cmd_q != CMD_WRITE && cmd_q != CMD_REFRESH)
      cke_q <= 1'b0;
    else if (!req_powerdown_i || state_q == ST_REFRESH)
      cke_q <= 1'b1;
  end

  // ----------------------------------------
  // Refresh debt
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ref_tmr_q <= '0;
      debt_q <= '0;
    end
    else
    begin
      ref_tmr_q <= (ref_tmr_q == 16'(REFRESH_CYC - 1)) ? '0 : ref_tmr_q + 1'b1;
      if (ref_tmr_q == 16'(REFRESH_CYC - 1) && cmd_q != CMD_REFRESH)
        debt_q <= (debt_q == 4'(POSTED_REFRESH_MAX)) ? debt_q : debt_q + 1'b1;
      else if (ref_tmr_q != 16'(REFRESH_CYC - 1) && cmd_q == CMD_REFRESH && debt_q != '0)
        debt_q <= debt_q - 1'b1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state_q <= ST_RUN;
    else
      case (state_q)
        ST_RUN:
          if (link.timing_fault)
            state_q <= ST_REINIT;
          else if (debt_q == 4'(POSTED_REFRESH_MAX))
            state_q <= ST_REFRESH;
        ST_REFRESH:
          if (cmd_q == CMD_REFRESH && debt_q <= 4'(1))
            state_q <= ST_RUN;
        ST_REINIT:
          state_q <= ST_REINIT;
        default:
          state_q <= ST_RUN;
      endcase
  end

  assign refresh_forced_o = (state_q == ST_REFRESH);
  assign refresh_debt_o = debt_q;
  assign reinit_needed_o = (state_q == ST_REINIT);
  assign link.cmd = cmd_q;
  assign link.burst = burst_q;
  assign link.termination_control = term_q;
  assign link.clock_enable = cke_q;
endmodule // dram_ctrl_end
`default_nettype wire

// file: dram_link_asserts.sv
// Checker for the command link joining the controller and device ends.
// Assumes the bench instantiates it beside the link, sharing clock and reset.
`timescale 1ns/1ns
`default_nettype none
module dram_link_asserts
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire dram_timing_pkg::dram_cmd_e cmd,
  input wire dram_timing_pkg::burst_e burst,
  input wire logic termination_control,
  input wire logic clock_enable,
  input wire logic loop_locked,
  input wire logic wr_start,
  input wire logic cal_busy,
  input wire logic timing_fault
);
  import dram_timing_pkg::*;
  // ----
  // Helpers
  // ----
  logic wr_full;
  logic wr_chop;
  logic [7:0] zq_q;
  logic [7:0] busy_q;
  assign wr_full = cmd == CMD_WRITE && burst != BURST_CHOP_FIX;
  assign wr_chop = cmd == CMD_WRITE && burst == BURST_CHOP_FIX;
  // Counts down the calibration quiet time
  always_ff @(posedge clk_i)
  begin
    if (reset_i) zq_q <= 8'h00;
    else if (cmd == CMD_ZQ_SHORT) zq_q <= 8'h3F;
    else if (zq_q != 8'h00) zq_q <= zq_q - 8'h01;
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !cal_busy) busy_q <= 8'h00;
    else busy_q <= busy_q + 8'h01;
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_long_start;
    $rose(termination_control) && cmd == CMD_WRITE && burst == BURST_EIGHT;
  endsequence
  sequence s_hold_short;
    termination_control [*4];
  endsequence
  sequence s_hold_long;
    termination_control [*6];
  endsequence
  sequence s_cke_kept;
    clock_enable [*2];
  endsequence
  AST_MODE_SPACING: assert property (cmd == CMD_MODE_SET |=> (cmd != CMD_MODE_SET) [*3])
    else $error("mode set repeated too soon");
  // Write latency 5 plus 4 or plus 2
  AST_WR_START_FULL: assert property (wr_full |-> ##9 wr_start)
    else $error("internal write start late or missing");
  AST_WR_START_CHOP: assert property (wr_chop |-> ##7 wr_start)
    else $error("chopped write start late or missing");
  AST_WR_START_CAUSE: assert property (wr_start |-> $past(wr_full, 9) || $past(wr_chop, 7))
    else $error("write start without a write");
  AST_CAL_START: assert property (cmd == CMD_ZQ_SHORT |-> ##[1:2] cal_busy)
    else $error("calibration did not start");
  AST_CAL_BOUND: assert property (cal_busy |-> busy_q < 8'h40)
    else $error("calibration longer than 64 cycles");
  AST_ZQ_QUIET: assert property (zq_q != 8'h00 |-> cmd == CMD_NOP)
    else $error("command during calibration");
  AST_TERM_SHORT: assert property ($rose(termination_control) && !(cmd == CMD_WRITE && burst == BURST_EIGHT)
    |-> s_hold_short)
    else $error("termination dropped before short hold");
  AST_TERM_LONG: assert property (s_long_start |-> s_hold_long)
    else $error("termination dropped before long hold");
  AST_LOCK: assert property (cmd == CMD_READ || cmd == CMD_READ_AP || $rose(termination_control) |-> loop_locked)
    else $error("locked command without lock");
  AST_NO_FAULT: assert property (!timing_fault)
    else $error("device saw illegal timing");
  AST_REF_TO_PD: assert property (cmd == CMD_REFRESH |-> s_cke_kept)
    else $error("clock enable dropped too soon after refresh");
endmodule // dram_link_asserts
`default_nettype wire

// file: test_sdram_command_timing_rules.sv
// Bench joining controller and device ends, plus a device fed illegal timing.
// Assumes the package constants and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module test_sdram_command_timing_rules;
  import dram_timing_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  dram_cmd_e req_cmd_i = CMD_NOP;
  burst_e req_burst_i = BURST_EIGHT;
  logic req_valid_i = 1'b0;
  logic req_term_i = 1'b0;
  logic req_powerdown_i = 1'b0;
  logic req_ready_o, refresh_forced_o, reinit_needed_o, wr_start_o, cal_busy_o, powered_down_o;
  logic timing_fault_o, fault_b;
  logic [3:0] refresh_debt_o;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0, acc = 0, n = 0, hi_run = 0, last_hi = 0, busy_run = 0, last_busy = 0;
  dram_cmd_e tbl [8] = '{CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE,
    CMD_WRITE, CMD_READ, CMD_READ_AP, CMD_READOUT};
  burst_e bk [3] = '{BURST_EIGHT, BURST_CHOP_OTF, BURST_CHOP_FIX};
  dram_cmd_if link (.clk_i(clk_i));
  dram_cmd_if link_b (.clk_i(clk_i));
  dram_ctrl_end #(.REFRESH_CYC(20)) dram_ctrl_end_inst (.clk_i(clk_i), .reset_i(reset_i), .link(link),
    .req_cmd_i(req_cmd_i), .req_burst_i(req_burst_i), .req_valid_i(req_valid_i), .req_term_i(req_term_i),
    .req_powerdown_i(req_powerdown_i), .req_ready_o(req_ready_o), .refresh_forced_o(refresh_forced_o),
    .refresh_debt_o(refresh_debt_o), .reinit_needed_o(reinit_needed_o));
  dram_device_end dram_device_end_inst (.clk_i(clk_i), .reset_i(reset_i), .link(link), .wr_start_o(wr_start_o),
    .cal_busy_o(cal_busy_o), .powered_down_o(powered_down_o), .timing_fault_o(timing_fault_o));
  // Second device, driven directly with a spacing fault
  dram_device_end dram_device_end_inst_b (.clk_i(clk_i), .reset_i(reset_i), .link(link_b), .wr_start_o(),
    .cal_busy_o(), .powered_down_o(), .timing_fault_o(fault_b));
  dram_link_asserts dram_link_asserts_inst (.clk_i(clk_i), .reset_i(reset_i), .cmd(link.cmd), .burst(link.burst),
    .termination_control(link.termination_control), .clock_enable(link.clock_enable),
    .loop_locked(link.loop_locked), .wr_start(link.wr_start), .cal_busy(link.cal_busy),
    .timing_fault(link.timing_fault));
  // ----
  // Clock, timeout, run lengths
  // ----
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  always @(negedge clk_i)
  begin
    if (link.termination_control) hi_run++;
    else if (hi_run != 0) begin last_hi = hi_run; hi_run = 0; end
    if (cal_busy_o) busy_run++;
    else if (busy_run != 0) begin last_busy = busy_run; busy_run = 0; end
  end
  // ----
  // Tasks
  // ----
  function automatic int wr_gap(input burst_e b);
    return WRITE_LATENCY_CYCLES + ((b == BURST_CHOP_FIX) ? WR_START_CHOP : WR_START_FULL);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until accepted, bounded so a stuck ready cannot hang
  task automatic issue(input dram_cmd_e c, input burst_e b, input logic t);
    int w;
    w = 0;
    @(negedge clk_i);
    req_cmd_i = c;
    req_burst_i = b;
    req_term_i = t;
    req_valid_i = 1'b1;
    do begin @(posedge clk_i); w++; end while (req_ready_o !== 1'b1 && w < 300);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    acc = cyc;
    chk(16'(link.cmd), 16'(c));
    if (w >= 300) n_mismatch++;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial
  begin
    link_b.cmd = CMD_NOP;
    link_b.burst = BURST_EIGHT;
    link_b.termination_control = 1'b0;
    link_b.clock_enable = 1'b1;
    void'($urandom(32'hcd23d993));
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    issue(CMD_MODE_SET, BURST_EIGHT, 1'b0);
    n = acc;
    issue(CMD_MODE_SET, BURST_EIGHT, 1'b0);
    chk(16'(acc - n), 16'(MODE_SET_SPACING));
    issue(CMD_ACTIVATE, BURST_EIGHT, 1'b0);
    foreach (bk[i])
    begin
      issue(CMD_WRITE, bk[i], 1'b0);
      n = 0;
      while (wr_start_o !== 1'b1 && n < 40) begin @(negedge clk_i); n++; end
      chk(16'(n), 16'(wr_gap(bk[i])));
    end
    issue(CMD_REFRESH, BURST_EIGHT, 1'b1);
    issue(CMD_PRECHARGE, BURST_EIGHT, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(16'(last_hi >= TERMINATION_HOLD_SHORT), 16'h1);
    issue(CMD_WRITE, BURST_EIGHT, 1'b1);
    issue(CMD_REFRESH, BURST_EIGHT, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(16'(last_hi >= TERMINATION_HOLD_LONG), 16'h1);
    issue(CMD_ZQ_SHORT, BURST_EIGHT, 1'b0);
    n = acc;
    issue(CMD_READ, BURST_EIGHT, 1'b0);
    chk(16'(acc - n >= IMPEDANCE_SHORT_CAL_CYC), 16'h1);
    repeat (2) @(negedge clk_i);
    chk(16'(last_busy > 0 && last_busy <= IMPEDANCE_SHORT_CAL_CYC), 16'h1);
    issue(CMD_REFRESH, BURST_EIGHT, 1'b0);
    req_powerdown_i = 1'b1;
    n = 0;
    while (powered_down_o !== 1'b1 && n < 20) begin @(negedge clk_i); n++; end
    chk(16'(link.clock_enable), 16'h0);
    req_powerdown_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk(16'(link.clock_enable), 16'h1);
    n = 0;
    while (refresh_forced_o !== 1'b1 && n < 400) begin @(negedge clk_i); n++; end
    chk(16'(refresh_debt_o), 16'(POSTED_REFRESH_MAX));
    n = 0;
    while (refresh_forced_o === 1'b1 && n < 12) begin issue(CMD_REFRESH, BURST_EIGHT, 1'b0); n++; end
    chk(16'(refresh_debt_o <= 4'h1), 16'h1);
    repeat (40)
    begin
      issue(tbl[$urandom_range(7)], burst_e'($urandom_range(2)), 1'b0);
      if ($urandom_range(1) == 0) issue(CMD_REFRESH, BURST_EIGHT, 1'b0);
    end
    chk(16'({reinit_needed_o, timing_fault_o}), 16'h0);
    @(negedge clk_i) link_b.cmd = CMD_MODE_SET;
    @(negedge clk_i) link_b.cmd = CMD_NOP;
    @(negedge clk_i) link_b.cmd = CMD_MODE_SET;
    @(negedge clk_i) link_b.cmd = CMD_NOP;
    repeat (3) @(negedge clk_i);
    chk(16'(fault_b), 16'h1);
    tally_and_finish();
  end
endmodule // test_sdram_command_timing_rules
`default_nettype wire
